// >>> design/pcsl_pkg.sv
// Function
// [RL1] active: ttl low, relay on, lamp lit
// [RL2] inactive: ttl high, relay off, lamp off
// [RL3] eight separate channels, each own outputs
// [RL4] auto mode follows rule condition
// [RL5] overrides from panel or host interface
// [RL6] commands: inactive, active, back to auto
// [RL7] power-up: all manual and inactive
// [RL8] never returns to auto by itself
// [RL9] four sources: reading, clock, ion, ttl
// [RL10] rule: source, setpoint, delay, audio
// [RL11] gauge off or faulty: fallback state
// [RL12] analog as output or overload: fallback
// [RL13] switched off: all relays de-energized
// [RL14] stays off until switched on manually
// [RL15] ion gauge settling freezes dependent rules
// [RL16] events logged with stamp, cleared at power; code logs only the lowest changed channel per cycle
// [RL17] delay filters changes, hysteresis separates thresholds
// [RL18] polarity selects below or above setpoint
package pcsl_pkg;
  localparam int NCH = 8;
  localparam int NRD = 4;
  localparam int LOG_DEPTH = 16;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_LOG = 8'h10;
  localparam logic [7:0] OFS_TIME = 8'h14;
  localparam logic [7:0] OFS_CH_BASE = 8'h40;
  localparam logic [7:0] OFS_CH_END = 8'hBF;
  localparam logic [1:0] CH_CFG = 2'h0;
  localparam logic [1:0] CH_LEVEL = 2'h1;
  localparam logic [1:0] CH_HYST = 2'h2;
  localparam logic [1:0] CH_DELAY = 2'h3;
  // field positions
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_SEL_LSB = 2;
  localparam int CFG_POL_BIT = 4;
  localparam int CFG_FB_BIT = 5;
  localparam int CFG_AUD_BIT = 6;
  localparam int CMD_CH_LSB = 0;
  localparam int CMD_OP_LSB = 4;
  localparam int STAT_AUTO_LSB = 8;
  localparam int STAT_PWR_BIT = 16;
  localparam int LOG_VALID_BIT = 20;
  // reset values and fixed choices
  localparam logic [15:0] RST_LEVEL = 16'h0000;
  localparam logic [15:0] RST_HYST = 16'h0000;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [1:0] ION_READ_IDX = 2'h0;

  typedef enum logic [1:0] {
    PCSL_SRC_READ = 2'b00,
    PCSL_SRC_TOD = 2'b01,
    PCSL_SRC_ION = 2'b10,
    PCSL_SRC_TTL = 2'b11
  } pcsl_src_e;

  typedef enum logic [1:0] {
    PCSL_OP_OFF = 2'b00,
    PCSL_OP_ON = 2'b01,
    PCSL_OP_AUTO = 2'b10
  } pcsl_op_e;

  typedef struct packed {
    pcsl_src_e src;
    logic [1:0] sel;
    logic pol;
    logic fallback;
    logic audio;
    logic [15:0] level;
    logic [15:0] hyst;
    logic [15:0] delay;
  } pcsl_rule_s;

  typedef struct packed {
    logic [NRD-1:0][15:0] value;
    logic [NRD-1:0] ok;
    logic [NRD-1:0] is_out;
    logic [NRD-1:0] ovl;
  } pcsl_gauge_s;

  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [1:0] op;
  } pcsl_cmd_s;

  typedef struct packed {
    logic [2:0] ch;
    logic st;
    logic [15:0] stamp;
  } pcsl_log_s;
endpackage : pcsl_pkg

// >>> design/pcsl_rule_eval.sv
`timescale 1ns/1ns
`default_nettype none
module pcsl_rule_eval (
  input wire logic CLK,
  input wire logic RST_N,
  input wire pcsl_pkg::pcsl_rule_s rule,
  input wire logic [15:0] value,
  input wire logic valid,
  input wire logic freeze,
  input wire logic tick,
  output logic active
);
  typedef struct packed {
    logic act;
    logic [15:0] cnt;
  } pcsl_ev_s;

  pcsl_ev_s s_r;
  pcsl_ev_s s_nxt;
  logic [16:0] hi_thr;
  logic [16:0] lo_thr;
  logic on_c;
  logic off_c;
  logic target;

  // thresholds kept 17 bits wide so level plus hysteresis cannot wrap
  assign hi_thr = {1'b0, rule.level} + {1'b0, rule.hyst};
  assign lo_thr = {1'b0, rule.level} - {1'b0, rule.hyst};
  // below: on under level, off above level+hyst; above mirrors it
  assign on_c = rule.pol ? (value > rule.level) : (value < rule.level); // RL18
  assign off_c = rule.pol ? (lo_thr[16] ? 1'b0 : ({1'b0, value} < lo_thr))
                          : ({1'b0, value} > hi_thr); // RL17
  assign target = s_r.act ? ~off_c : on_c;

  // delay counts ms ticks while the new condition holds unbroken
  always_comb begin
    s_nxt = s_r;
    if (!valid) begin
      s_nxt.act = rule.fallback; // RL11 RL12
      s_nxt.cnt = 16'h0000;
    end else if (freeze) begin
      s_nxt = s_r; // RL15
    end else if (target == s_r.act) begin
      s_nxt.cnt = 16'h0000; // RL17
    end else if (s_r.cnt >= rule.delay) begin
      s_nxt.act = target; // RL17
      s_nxt.cnt = 16'h0000;
    end else if (tick) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active = s_r.act;
endmodule : pcsl_rule_eval
`default_nettype wire

// >>> design/pcsl_top.sv
`timescale 1ns/1ns
`default_nettype none
module pcsl_top #(
  parameter int TICK_CYCLES = pcsl_pkg::TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire pcsl_pkg::pcsl_cmd_s PANEL_CMD,
  input wire logic PWR_KEY,
  input wire pcsl_pkg::pcsl_gauge_s GAUGE,
  input wire logic [15:0] TOD_MIN,
  input wire logic ION_EMIS,
  input wire logic ION_SETTLING,
  input wire logic [7:0] TTL_IN,
  output logic [7:0] RELAY,
  output logic [7:0] TTL_OUT_N,
  output logic [7:0] LAMP,
  output logic AUDIO,
  output logic IRQ,
  output logic POWERED
);
  localparam int LW = $clog2(pcsl_pkg::LOG_DEPTH);

  typedef struct packed {
    logic pwr;
    logic [7:0] act;
    logic [7:0] autom;
    logic [7:0] ttl_n;
    logic [7:0] irq_st;
    logic [7:0] irq_mask;
    logic irq;
    logic aud;
    logic [31:0] rdata;
    logic [16:0] tick_cnt;
    logic tick;
    logic [15:0] stamp;
    logic [7:0][54:0] rules;
    logic [pcsl_pkg::LOG_DEPTH-1:0][19:0] log;
    logic [LW-1:0] wp;
    logic [LW-1:0] rp;
    logic [LW:0] cnt;
  } pcsl_st_s;

  pcsl_st_s s_r;
  pcsl_st_s s_nxt;
  logic [7:0] rule_act;
  logic [7:0] ch_valid;
  logic [7:0] ch_freeze;
  logic [7:0][15:0] ch_value;

  // channel registers sit in 16-byte blocks from the channel base
  function automatic logic is_chan(input logic [7:0] a);
    return (a >= pcsl_pkg::OFS_CH_BASE) && (a <= pcsl_pkg::OFS_CH_END);
  endfunction : is_chan

  function automatic logic [2:0] chan_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - pcsl_pkg::OFS_CH_BASE;
    return d[6:4];
  endfunction : chan_of

  function automatic pcsl_pkg::pcsl_rule_s rule_of(input logic [54:0] raw);
    return pcsl_pkg::pcsl_rule_s'(raw);
  endfunction : rule_of

  // source selection per channel; reading validity drives fallback
  for (genvar i = 0; i < pcsl_pkg::NCH; i++) begin : g_ch
    pcsl_pkg::pcsl_rule_s r;
    assign r = rule_of(s_r.rules[i]);
    always_comb begin
      ch_value[i] = 16'h0000;
      ch_valid[i] = 1'b1;
      ch_freeze[i] = 1'b0;
      unique case (r.src)
        pcsl_pkg::PCSL_SRC_READ: begin
          ch_value[i] = GAUGE.value[r.sel]; // RL9
          ch_valid[i] = GAUGE.ok[r.sel] & ~GAUGE.is_out[r.sel] & ~GAUGE.ovl[r.sel]; // RL11 RL12
          ch_freeze[i] = ION_SETTLING && (r.sel == pcsl_pkg::ION_READ_IDX); // RL15
        end
        pcsl_pkg::PCSL_SRC_TOD: begin
          ch_value[i] = TOD_MIN; // RL9
        end
        pcsl_pkg::PCSL_SRC_ION: begin
          ch_value[i] = {15'h0000, ION_EMIS}; // RL9
          ch_freeze[i] = ION_SETTLING; // RL15
        end
        pcsl_pkg::PCSL_SRC_TTL: begin
          ch_value[i] = {15'h0000, TTL_IN[i]}; // RL9
        end
      endcase
    end
    pcsl_rule_eval pcsl_rule_eval_i (
      .CLK(CLK),
      .RST_N(RST_N),
      .rule(r),
      .value(ch_value[i]),
      .valid(ch_valid[i]),
      .freeze(ch_freeze[i]),
      .tick(s_r.tick),
      .active(rule_act[i])
    );
  end

  // whole next state; set of a sticky bit beats its clear
  always_comb begin
    logic [7:0] chg;
    logic [7:0] aud_en;
    logic host_cmd;
    logic [2:0] hch;
    logic [1:0] hop;
    logic pop;
    logic push;
    logic [2:0] lch;
    logic [1:0] fld;
    pcsl_pkg::pcsl_log_s ent;
    pcsl_pkg::pcsl_rule_s rr;
    chg = 8'h00;
    aud_en = 8'h00;
    host_cmd = 1'b0;
    hch = 3'h0;
    hop = 2'h0;
    pop = 1'b0;
    push = 1'b0;
    lch = 3'h0;
    fld = 2'h0;
    ent = '0;
    rr = '0;
    s_nxt = s_r;
    s_nxt.rdata = 32'h0000_0000;
    s_nxt.tick = 1'b0;

    // millisecond tick and time stamp
    if (s_r.tick_cnt >= 17'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = 17'h0_0000;
      s_nxt.tick = 1'b1;
      s_nxt.stamp = s_r.stamp + 16'h0001;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 17'h0_0001;
    end

    // auto channels follow their rule while powered
    for (int i = 0; i < pcsl_pkg::NCH; i++) begin
      if (s_r.autom[i]) begin
        s_nxt.act[i] = rule_act[i]; // RL4
      end
    end

    // host commands through the register port
    if (WR && (ADDR == pcsl_pkg::OFS_CMD)) begin
      host_cmd = 1'b1;
      hch = WDATA[pcsl_pkg::CMD_CH_LSB +: 3];
      hop = WDATA[pcsl_pkg::CMD_OP_LSB +: 2];
    end
    // host applied first so the panel wins a same-channel clash
    if (host_cmd) begin
      unique case (hop)
        pcsl_pkg::PCSL_OP_OFF: begin
          s_nxt.autom[hch] = 1'b0; // RL6
          s_nxt.act[hch] = 1'b0; // RL5
        end
        pcsl_pkg::PCSL_OP_ON: begin
          s_nxt.autom[hch] = 1'b0; // RL6
          s_nxt.act[hch] = 1'b1; // RL5
        end
        pcsl_pkg::PCSL_OP_AUTO: begin
          s_nxt.autom[hch] = 1'b1; // RL6
        end
        default: begin
        end
      endcase
    end
    if (PANEL_CMD.valid) begin
      unique case (PANEL_CMD.op)
        pcsl_pkg::PCSL_OP_OFF: begin
          s_nxt.autom[PANEL_CMD.ch] = 1'b0; // RL6
          s_nxt.act[PANEL_CMD.ch] = 1'b0; // RL5
        end
        pcsl_pkg::PCSL_OP_ON: begin
          s_nxt.autom[PANEL_CMD.ch] = 1'b0; // RL6
          s_nxt.act[PANEL_CMD.ch] = 1'b1; // RL5
        end
        pcsl_pkg::PCSL_OP_AUTO: begin
          s_nxt.autom[PANEL_CMD.ch] = 1'b1; // RL6
        end
        default: begin
        end
      endcase
    end

    // power key toggles; every switch-on starts manual and inactive
    if (PWR_KEY) begin
      s_nxt.pwr = ~s_r.pwr; // RL14
    end
    if (!s_r.pwr || PWR_KEY) begin
      s_nxt.autom = 8'h00; // RL7 RL8
      s_nxt.act = 8'h00; // RL13
    end

    // events: state changes raise sticky bits and audio
    chg = s_nxt.act ^ s_r.act;
    for (int i = 0; i < pcsl_pkg::NCH; i++) begin
      rr = rule_of(s_r.rules[i]);
      aud_en[i] = rr.audio;
    end
    s_nxt.aud = |(chg & aud_en); // RL10
    s_nxt.ttl_n = ~s_nxt.act; // RL1 RL2

    // register writes
    if (WR && (ADDR == pcsl_pkg::OFS_IRQ_ST)) begin
      s_nxt.irq_st = s_r.irq_st & ~WDATA[7:0];
    end
    s_nxt.irq_st = s_nxt.irq_st | chg;
    if (WR && (ADDR == pcsl_pkg::OFS_IRQ_MASK)) begin
      s_nxt.irq_mask = WDATA[7:0];
    end
    if (WR && is_chan(ADDR)) begin
      lch = chan_of(ADDR);
      fld = ADDR[3:2];
      unique case (fld)
        // register layout differs from the packed rule order, map field by field
        pcsl_pkg::CH_CFG: begin
          s_nxt.rules[lch][54:53] = WDATA[pcsl_pkg::CFG_SRC_LSB +: 2]; // RL10
          s_nxt.rules[lch][52:51] = WDATA[pcsl_pkg::CFG_SEL_LSB +: 2];
          s_nxt.rules[lch][50] = WDATA[pcsl_pkg::CFG_POL_BIT];
          s_nxt.rules[lch][49] = WDATA[pcsl_pkg::CFG_FB_BIT];
          s_nxt.rules[lch][48] = WDATA[pcsl_pkg::CFG_AUD_BIT];
        end
        pcsl_pkg::CH_LEVEL: s_nxt.rules[lch][47:32] = WDATA[15:0];
        pcsl_pkg::CH_HYST: s_nxt.rules[lch][31:16] = WDATA[15:0];
        pcsl_pkg::CH_DELAY: s_nxt.rules[lch][15:0] = WDATA[15:0];
      endcase
    end
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

    // register reads, data one cycle later
    if (RD) begin
      if (ADDR == pcsl_pkg::OFS_STATUS) begin
        s_nxt.rdata[7:0] = s_r.act;
        s_nxt.rdata[pcsl_pkg::STAT_AUTO_LSB +: 8] = s_r.autom;
        s_nxt.rdata[pcsl_pkg::STAT_PWR_BIT] = s_r.pwr;
      end else if (ADDR == pcsl_pkg::OFS_IRQ_ST) begin
        s_nxt.rdata[7:0] = s_r.irq_st;
      end else if (ADDR == pcsl_pkg::OFS_IRQ_MASK) begin
        s_nxt.rdata[7:0] = s_r.irq_mask;
      end else if (ADDR == pcsl_pkg::OFS_TIME) begin
        s_nxt.rdata[15:0] = s_r.stamp;
      end else if (ADDR == pcsl_pkg::OFS_LOG) begin
        if (s_r.cnt != '0) begin
          pop = 1'b1;
          s_nxt.rdata[19:0] = s_r.log[s_r.rp]; // RL16
          s_nxt.rdata[pcsl_pkg::LOG_VALID_BIT] = 1'b1;
        end
      end else if (is_chan(ADDR)) begin
        lch = chan_of(ADDR);
        unique case (ADDR[3:2])
          pcsl_pkg::CH_CFG: begin
            s_nxt.rdata[pcsl_pkg::CFG_SRC_LSB +: 2] = s_r.rules[lch][54:53];
            s_nxt.rdata[pcsl_pkg::CFG_SEL_LSB +: 2] = s_r.rules[lch][52:51];
            s_nxt.rdata[pcsl_pkg::CFG_POL_BIT] = s_r.rules[lch][50];
            s_nxt.rdata[pcsl_pkg::CFG_FB_BIT] = s_r.rules[lch][49];
            s_nxt.rdata[pcsl_pkg::CFG_AUD_BIT] = s_r.rules[lch][48];
          end
          pcsl_pkg::CH_LEVEL: s_nxt.rdata[15:0] = s_r.rules[lch][47:32];
          pcsl_pkg::CH_HYST: s_nxt.rdata[15:0] = s_r.rules[lch][31:16];
          pcsl_pkg::CH_DELAY: s_nxt.rdata[15:0] = s_r.rules[lch][15:0];
        endcase
      end
    end

    // event log keeps the lowest changed channel; full log drops new events
    for (int i = pcsl_pkg::NCH - 1; i >= 0; i--) begin
      if (chg[i]) begin
        ent.ch = 3'(i);
        ent.st = s_nxt.act[i];
        push = 1'b1;
      end
    end
    ent.stamp = s_r.stamp;
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && (s_r.cnt != (LW + 1)'(pcsl_pkg::LOG_DEPTH))) begin
      s_nxt.log[s_r.wp] = ent; // RL16
      s_nxt.wp = s_r.wp + 1'b1;
      s_nxt.cnt = pop ? s_r.cnt : s_r.cnt + 1'b1;
    end else if (pop) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  // power-on reset clears the log and leaves the unit switched off
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '0; // RL7 RL14 RL16
      s_r.ttl_n <= 8'hFF; // RL2
      s_r.irq_mask <= pcsl_pkg::RST_MASK;
      for (int i = 0; i < pcsl_pkg::NCH; i++) begin
        s_r.rules[i][47:32] <= pcsl_pkg::RST_LEVEL;
        s_r.rules[i][31:16] <= pcsl_pkg::RST_HYST;
        s_r.rules[i][15:0] <= pcsl_pkg::RST_DELAY;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state flops, one per channel
  assign RELAY = s_r.act; // RL1 RL2 RL3
  assign LAMP = s_r.act; // RL1 RL2
  assign TTL_OUT_N = s_r.ttl_n; // RL1 RL2
  assign AUDIO = s_r.aud;
  assign IRQ = s_r.irq;
  assign RDATA = s_r.rdata;
  assign POWERED = s_r.pwr;
endmodule : pcsl_top
`default_nettype wire

// >>> testbench/pcsl_plant_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcsl_plant_model (
  input wire logic CLK,
  output var pcsl_pkg::pcsl_cmd_s PANEL_CMD,
  output var pcsl_pkg::pcsl_gauge_s GAUGE,
  output var logic [15:0] TOD_MIN,
  output var logic ION_EMIS,
  output var logic ION_SETTLING,
  output var logic [7:0] TTL_IN
);
  // quiet plant, all gauges off at power-up
  initial begin
    PANEL_CMD = '0;
    GAUGE = '0;
    TOD_MIN = 16'h0000;
    ION_EMIS = 1'b0;
    ION_SETTLING = 1'b0;
    TTL_IN = 8'h00;
  end
  // operator touches one channel box, one-cycle strobe
  task press(input logic [2:0] c, input logic [1:0] o);
    @(posedge CLK);
    PANEL_CMD <= '{1'b1, c, o};
    @(posedge CLK);
    PANEL_CMD.valid <= 1'b0;
  endtask : press
  // f holds ok, configured as output, overload
  task setg(input int i, input logic [15:0] v, input logic [2:0] f);
    @(posedge CLK);
    GAUGE.value[i] <= v;
    GAUGE.ok[i] <= f[2];
    GAUGE.is_out[i] <= f[1];
    GAUGE.ovl[i] <= f[0];
  endtask : setg
  task lvl(input logic [15:0] t, input logic e, input logic s, input logic [7:0] x);
    @(posedge CLK);
    TOD_MIN <= t;
    ION_EMIS <= e;
    ION_SETTLING <= s;
    TTL_IN <= x;
  endtask : lvl
endmodule : pcsl_plant_model
`default_nettype wire

// >>> testbench/pcsl_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module pcsl_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire pcsl_pkg::pcsl_cmd_s PANEL_CMD,
  input wire logic PWR_KEY,
  input wire logic [7:0] RELAY,
  input wire logic [7:0] TTL_OUT_N,
  input wire logic [7:0] LAMP,
  input wire logic POWERED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // the three outputs of a channel never disagree
  a_ttl_inverse: assert property (TTL_OUT_N == ~RELAY)
    else $error("ttl output not inverse of relay");
  a_lamp_relay: assert property (LAMP == RELAY)
    else $error("lamp differs from relay");
  // switched off means every contact at rest
  a_off_dark: assert property (!POWERED |-> RELAY == 8'h00)
    else $error("relay energized while off");
  a_off_holds: assert property (!POWERED && !PWR_KEY |=> !POWERED)
    else $error("unit came on without key");
  a_key_toggle: assert property (PWR_KEY |=> POWERED != $past(POWERED))
    else $error("key did not toggle power");
  a_key_clear: assert property (PWR_KEY |=> RELAY == 8'h00)
    else $error("channels not inactive after key");
  // panel override lands one cycle later
  a_cmd_on: assert property (
    PANEL_CMD.valid && PANEL_CMD.op == 2'h1 && POWERED && !PWR_KEY
    |=> RELAY[$past(PANEL_CMD.ch)])
    else $error("panel active command missed");
  a_cmd_off: assert property (
    PANEL_CMD.valid && PANEL_CMD.op == 2'h0 && POWERED && !PWR_KEY
    |=> !RELAY[$past(PANEL_CMD.ch)])
    else $error("panel inactive command missed");
  a_rd_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read slot");
endmodule : pcsl_checker
bind pcsl_top pcsl_checker pcsl_checker_i (.CLK(CLK), .RST_N(RST_N), .RD(RD), .RDATA(RDATA),
  .PANEL_CMD(PANEL_CMD), .PWR_KEY(PWR_KEY), .RELAY(RELAY), .TTL_OUT_N(TTL_OUT_N),
  .LAMP(LAMP), .POWERED(POWERED));
`default_nettype wire

// >>> testbench/pcsl_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module pcsl_top_test;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic PWR_KEY = 1'b0;
  pcsl_pkg::pcsl_cmd_s PANEL_CMD;
  pcsl_pkg::pcsl_gauge_s GAUGE;
  logic [15:0] TOD_MIN;
  logic ION_EMIS;
  logic ION_SETTLING;
  logic [7:0] TTL_IN;
  logic [7:0] RELAY;
  logic [7:0] TTL_OUT_N;
  logic [7:0] LAMP;
  logic [31:0] RDATA;
  logic AUDIO;
  logic IRQ;
  logic POWERED;
  logic [31:0] d;
  logic [7:0] e;
  int n_fail = 0;
  int n_compared = 0;
  always #5 CLK = ~CLK;
  // short ms tick keeps delay tests brief
  pcsl_top #(.TICK_CYCLES(10)) pcsl_top_i (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PANEL_CMD(PANEL_CMD),
    .PWR_KEY(PWR_KEY), .GAUGE(GAUGE), .TOD_MIN(TOD_MIN), .ION_EMIS(ION_EMIS),
    .ION_SETTLING(ION_SETTLING), .TTL_IN(TTL_IN), .RELAY(RELAY), .TTL_OUT_N(TTL_OUT_N),
    .LAMP(LAMP), .AUDIO(AUDIO), .IRQ(IRQ), .POWERED(POWERED));
  pcsl_plant_model pcsl_plant_model_i (.CLK(CLK), .PANEL_CMD(PANEL_CMD), .GAUGE(GAUGE),
    .TOD_MIN(TOD_MIN), .ION_EMIS(ION_EMIS), .ION_SETTLING(ION_SETTLING), .TTL_IN(TTL_IN));
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // settle past the edge so registered outputs have landed
  task wt(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
  task key();
    @(posedge CLK);
    PWR_KEY <= 1'b1;
    @(posedge CLK);
    PWR_KEY <= 1'b0;
  endtask : key
  task hcmd(input logic [2:0] c, input logic [1:0] o);
    wr(8'h04, {26'h0, o, 1'b0, c});
  endtask : hcmd
  // program a rule, then hand the channel to auto
  task rule(input int c, input logic [6:0] cfg, input logic [15:0] lv, hy, dl);
    logic [7:0] b;
    b = 8'(64 + 16 * c);
    wr(b, {25'h0, cfg});
    wr(b + 8'h04, {16'h0, lv});
    wr(b + 8'h08, {16'h0, hy});
    wr(b + 8'h0C, {16'h0, dl});
    hcmd(3'(c), 2'h2);
  endtask : rule
  task seq(input logic [15:0] v, input logic [2:0] f, input logic x);
    pcsl_plant_model_i.setg(1, v, f);
    wt(5);
    chk("ch1", {31'h0, RELAY[1]}, {31'h0, x});
  endtask : seq
  task t_reset();
    chk("outs", {LAMP, TTL_OUT_N, RELAY, 8'h00}, 32'h00FF0000);
    chk("pwr", {31'h0, POWERED}, 32'h0);
    pcsl_plant_model_i.press(3'h1, 2'h1);
    wt(2);
    chk("ignored", {24'h0, RELAY}, 32'h0);
    key();
    wt(1);
    chk("on", {23'h0, POWERED, RELAY}, 32'h100);
  endtask : t_reset
  // each channel on its own, set by panel and host alternating, cleared by panel
  task t_manual();
    e = 8'h00;
    for (int c = 0; c < 8; c++) begin
      if (c % 2 == 0) pcsl_plant_model_i.press(3'(c), 2'h1);
      else hcmd(3'(c), 2'h1);
      e[c] = 1'b1;
      wt(2);
      chk("act", {8'h00, LAMP, TTL_OUT_N, RELAY}, {8'h00, e, ~e, e});
    end
    for (int c = 0; c < 8; c++) begin
      pcsl_plant_model_i.press(3'(c), 2'h0);
      e[c] = 1'b0;
      wt(2);
      chk("inact", {8'h00, LAMP, TTL_OUT_N, RELAY}, {8'h00, e, ~e, e});
    end
    // unused op code must leave the channel alone
    hcmd(3'h0, 2'h3);
    wt(2);
    chk("op3", {24'h0, RELAY}, 32'h0);
  endtask : t_manual
  // reading 1 on ch1: hysteresis band, polarity, fallback
  task t_rule();
    pcsl_plant_model_i.setg(1, 16'h0078, 3'b100);
    rule(1, 7'h04, 16'h0064, 16'h000A, 16'h0000);
    seq(16'h0032, 3'b100, 1'b1);
    seq(16'h0069, 3'b100, 1'b1);
    seq(16'h0078, 3'b100, 1'b0);
    seq(16'h0069, 3'b100, 1'b0);
    wr(8'h50, 32'h14);
    seq(16'h0078, 3'b100, 1'b1);
    seq(16'h0055, 3'b100, 1'b0);
    wr(8'h50, 32'h24);
    seq(16'h0078, 3'b000, 1'b1);
    seq(16'h0078, 3'b100, 1'b0);
    seq(16'h0078, 3'b110, 1'b1);
    seq(16'h0078, 3'b100, 1'b0);
    seq(16'h0078, 3'b101, 1'b1);
    pcsl_plant_model_i.press(3'h1, 2'h0);
    seq(16'h0078, 3'b000, 1'b0);
    // panel hands the channel back to its rule
    pcsl_plant_model_i.press(3'h1, 2'h2);
    seq(16'h0078, 3'b000, 1'b1);
    seq(16'h0078, 3'b100, 1'b0);
  endtask : t_rule
  // one channel per source, all start low then rise
  task t_src();
    // polarity above, so any value over zero activates
    for (int s = 0; s < 4; s++) rule(s + 2, 7'(s + 24), 16'h0000, 16'h0000, 16'h0000);
    wt(5);
    chk("low", {28'h0, RELAY[5:2]}, 32'h0);
    pcsl_plant_model_i.setg(2, 16'h0005, 3'b100);
    pcsl_plant_model_i.lvl(16'h0001, 1'b1, 1'b0, 8'h20);
    wt(5);
    chk("high", {28'h0, RELAY[5:2]}, 32'hF);
  endtask : t_src
  // three ms delay, then freeze while the ion gauge settles
  task t_delay();
    rule(6, 7'h13, 16'h0000, 16'h0000, 16'h0003);
    pcsl_plant_model_i.lvl(16'h0001, 1'b1, 1'b0, 8'h60);
    wt(15);
    chk("early", {31'h0, RELAY[6]}, 32'h0);
    wt(35);
    chk("late", {31'h0, RELAY[6]}, 32'h1);
    pcsl_plant_model_i.setg(0, 16'h0000, 3'b100);
    rule(7, 7'h10, 16'h0000, 16'h0000, 16'h0000);
    pcsl_plant_model_i.lvl(16'h0001, 1'b1, 1'b1, 8'h60);
    pcsl_plant_model_i.setg(0, 16'h0009, 3'b100);
    wt(10);
    chk("frozen", {31'h0, RELAY[7]}, 32'h0);
    pcsl_plant_model_i.lvl(16'h0001, 1'b1, 1'b0, 8'h60);
    wt(5);
    chk("thawed", {31'h0, RELAY[7]}, 32'h1);
  endtask : t_delay
  task t_irq();
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'hFF);
    wt(1);
    chk("irq0", {31'h0, IRQ}, 32'h0);
    // audio enabled on ch0, pulse stands one cycle with the change
    wr(8'h40, 32'h40);
    pcsl_plant_model_i.press(3'h0, 2'h1);
    #1;
    chk("aud", {31'h0, AUDIO}, 32'h1);
    wt(2);
    chk("irq1", {31'h0, IRQ}, 32'h1);
    chk("aud0", {31'h0, AUDIO}, 32'h0);
    rd(8'h00);
    chk("status", d, 32'h1FEFD);
    wr(8'h08, 32'h1);
    wt(1);
    chk("irqclr", {31'h0, IRQ}, 32'h0);
    wr(8'h0C, 32'h0);
    pcsl_plant_model_i.press(3'h0, 2'h0);
    wt(2);
    chk("masked", {31'h0, IRQ}, 32'h0);
    rd(8'h08);
    chk("sticky", {31'h0, d[0]}, 32'h1);
    rd(8'h30);
    chk("unmapped", d, 32'h0);
  endtask : t_irq
  // auto channels must not come back after a power cycle
  task t_power();
    key();
    wt(2);
    chk("off", {23'h0, POWERED, RELAY}, 32'h0);
    key();
    wt(5);
    chk("back", {23'h0, POWERED, RELAY}, 32'h100);
    rd(8'h00);
    chk("manual", d, 32'h10000);
    // oldest entry is ch0 going active
    rd(8'h10);
    chk("log", {27'h0, d[20:16]}, 32'h11);
    // power removed mid-run: unit off, log empty
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    wt(1);
    chk("rst", {23'h0, POWERED, RELAY}, 32'h0);
    rd(8'h10);
    chk("logclr", d, 32'h0);
  endtask : t_power
  initial begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    wt(1);
    t_reset();
    t_manual();
    t_rule();
    t_src();
    t_delay();
    t_irq();
    t_power();
    end_sim();
  end
  // whole run is a few hundred cycles
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : pcsl_top_test
`default_nettype wire
